// ### hw/ofm_freq_cmp.sv
// Frequency comparator: counts main oscillator edges per divided RC period.
// Assumes both oscillator levels arrive already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ofm_freq_cmp
  import ofm_pkg::*;
#(
  parameter int RC_DIV = OFM_RC_DIVIDE,
  parameter int CNT_W = OFM_EDGE_CNT_W
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic main_osc_in,
  input wire logic rc_osc_in,
  output logic meas_valid,
  output logic main_slow
);

  localparam int DW = $clog2(RC_DIV);

  // ----------------------------------------------------------------
  // Parameter checks.
  // ----------------------------------------------------------------
  if (RC_DIV < 2 || CNT_W < 1)
  begin : g_bad_param
    $error("ofm_freq_cmp: RC_DIV must be at least 2 and CNT_W at least 1.");
  end

  typedef struct packed {
    logic main_q;
    logic rc_q;
    logic [DW-1:0] div_cnt;
    logic [CNT_W-1:0] edge_cnt;
    logic valid;
    logic slow;
  } ofm_cmp_s;

  ofm_cmp_s st_r;
  ofm_cmp_s st_nxt;
  logic main_rise;
  logic rc_rise;

  assign main_rise = main_osc_in & ~st_r.main_q;
  assign rc_rise = rc_osc_in & ~st_r.rc_q;

  // Main edges are counted inside a window of five RC edges; a window with no
  // main edge at all means the main clock runs slower than the reference.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.main_q = main_osc_in;
    st_nxt.rc_q = rc_osc_in;
    st_nxt.valid = 1'b0;
    if (main_rise && st_r.edge_cnt != {CNT_W{1'b1}})
    begin
      st_nxt.edge_cnt = st_r.edge_cnt + 1'b1; // R17
    end
    if (rc_rise)
    begin
      if (st_r.div_cnt == DW'(RC_DIV - 1))
      begin
        st_nxt.div_cnt = '0; // R1
        st_nxt.valid = 1'b1;
        st_nxt.slow = (st_r.edge_cnt == '0) && !main_rise; // R2
        st_nxt.edge_cnt = '0;
      end
      else
      begin
        st_nxt.div_cnt = st_r.div_cnt + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign meas_valid = st_r.valid;
  assign main_slow = st_r.slow;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  AST_DIV_WINDOW: assert property (@(posedge clk) disable iff (sys_rst) // R1
    meas_valid |-> $past(rc_rise) && $past(st_r.div_cnt) == DW'(RC_DIV - 1))
    else $error("Measurement closed without five reference edges.");

endmodule
`default_nettype wire

// ### hw/ofm_monitor.sv
// Oscillator failure monitor with its reset status register.
// Assumes the core drives the register port and resets itself from chip_rst.
//
// Contract
// R1: Divide RC reference by five, compare with main oscillator frequency.
// R2: Main slower than divided reference means oscillator failure.
// R3: On failure switch the system clock to the RC source.
// R4: On failure assert internal reset alongside the clock switch.
// R5: Failure reset behaves like external reset apart from listed exceptions.
// R6: Failure reset leaves the timer watchdog status flag unchanged.
// R7: Failure reset stops the software watchdog like an external reset.
// R8: Recovery starts a final reset phase of about one millisecond.
// R9: During final phase keep RC clock and hold chip in reset.
// R10: After final phase return to main clock and drop reset request.
// R11: Chip stays reset while external reset remains asserted.
// R12: Set oscillator failure flag whenever the monitor forced a reset.
// R13: Software can write the oscillator failure flag both ways.
// R14: External reset clears both status flags.
// R15: Status register reads all zeros after reset.
// R16: Monitor is always active; no enable exists.
// R17: Count main edges per divided reference period before deciding.
`timescale 1ns/1ps
`default_nettype none
module ofm_monitor
  import ofm_pkg::*;
#(
  parameter int FINAL_CYCLES = OFM_FINAL_CYCLES
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic main_osc_in,
  input wire logic rc_osc_in,
  input wire logic ext_rst_req,
  input wire logic wdt_rst_evt,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic clk_sel_rc,
  output logic osc_rst_req,
  output logic chip_rst,
  output logic wdt_stop
);

  localparam int FW = $clog2(FINAL_CYCLES + 1);

  // ----------------------------------------------------------------
  // Parameter checks.
  // ----------------------------------------------------------------
  // The final phase must span at least two cycles so that reset is seen held.
  if (FINAL_CYCLES < 2)
  begin : g_bad_param
    $error("ofm_monitor: FINAL_CYCLES must be at least 2.");
  end

  typedef enum logic [1:0] {
    OFM_RUN,
    OFM_FAIL,
    OFM_FINAL
  } ofm_state_e;

  typedef struct packed {
    ofm_state_e state;
    logic [FW-1:0] final_cnt;
    logic osc_flag;
    logic wdt_flag;
    logic [OFM_PRIO_MSB:0] prio;
    logic [7:0] rdata;
  } ofm_mon_s;

  ofm_mon_s st_r;
  ofm_mon_s st_nxt;
  logic meas_valid;
  logic main_slow;
  logic reg_wr;
  logic [7:0] reg_val;

  // Address decode shared by the write and the read path.
  function automatic logic hits_status(input logic [7:0] addr);
    hits_status = (addr == OFM_STATUS_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // Frequency comparison; runs unconditionally, there is no enable.
  // ----------------------------------------------------------------
  ofm_freq_cmp #(
    .RC_DIV(OFM_RC_DIVIDE),
    .CNT_W(OFM_EDGE_CNT_W)
  ) u_cmp (
    .clk(clk),
    .sys_rst(sys_rst),
    .main_osc_in(main_osc_in),
    .rc_osc_in(rc_osc_in),
    .meas_valid(meas_valid),
    .main_slow(main_slow)
  ); // R16

  // ----------------------------------------------------------------
  // Decoded outputs.
  // ----------------------------------------------------------------
  // The clock select and the reset request come from the same state decode, so
  // the core can never run from the RC reference clock while out of reset.
  assign clk_sel_rc = (st_r.state != OFM_RUN); // R3 R9
  assign osc_rst_req = (st_r.state != OFM_RUN); // R4 R9
  assign chip_rst = osc_rst_req | ext_rst_req; // R5 R11
  assign wdt_stop = chip_rst; // R7
  assign sfr_rdata = st_r.rdata;

  assign reg_wr = sfr_wr && hits_status(sfr_addr);
  assign reg_val = {st_r.osc_flag, st_r.wdt_flag, st_r.prio};

  // Supervisor sequence, status flags and register access.
  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r.state)
      OFM_RUN:
      begin
        if (meas_valid && main_slow)
          st_nxt.state = OFM_FAIL; // R2 R3 R4
      end
      OFM_FAIL:
      begin
        if (meas_valid && !main_slow)
        begin
          st_nxt.state = OFM_FINAL; // R8
          st_nxt.final_cnt = '0;
        end
      end
      OFM_FINAL:
      begin
        if (meas_valid && main_slow)
          st_nxt.state = OFM_FAIL;
        else if (st_r.final_cnt == FW'(FINAL_CYCLES - 1))
          st_nxt.state = OFM_RUN; // R10
        else
          st_nxt.final_cnt = st_r.final_cnt + 1'b1; // R8
      end
      // An illegal code is treated as a failure, so the chip stays in reset
      // until a good measurement window starts the final phase.
      default:
      begin
        st_nxt.state = OFM_FAIL;
      end
    endcase

    // Priority bits clear on any chip reset; the flags carry the exceptions.
    if (chip_rst)
      st_nxt.prio = '0; // R5
    else if (reg_wr)
      st_nxt.prio = sfr_wdata[OFM_PRIO_MSB:0];

    // Hardware set beats every clear so a forced reset is never lost.
    if (ext_rst_req)
      st_nxt.osc_flag = 1'b0; // R14
    else if (reg_wr)
      st_nxt.osc_flag = sfr_wdata[OFM_OSC_FLAG_BIT]; // R13
    if (osc_rst_req)
      st_nxt.osc_flag = 1'b1; // R12

    // The failure reset does not touch the timer watchdog flag.
    if (ext_rst_req)
      st_nxt.wdt_flag = 1'b0; // R14
    else if (reg_wr && !osc_rst_req)
      st_nxt.wdt_flag = sfr_wdata[OFM_WDT_FLAG_BIT]; // R6
    if (wdt_rst_evt)
      st_nxt.wdt_flag = 1'b1;

    // Read data is registered; a miss reads zero.
    if (sfr_rd && hits_status(sfr_addr))
      st_nxt.rdata = reg_val;
    else
      st_nxt.rdata = 8'h00;
  end

  // State register; power-on clears the status register.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '0; // R15
      st_r.state <= OFM_RUN;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  AST_FAIL_SWITCH: assert property (@(posedge clk) disable iff (sys_rst) // R3
    st_r.state == OFM_RUN && meas_valid && main_slow |=> clk_sel_rc && osc_rst_req)
    else $error("Failure did not switch to the reference clock.");

  AST_SEL_WITH_RESET: assert property (@(posedge clk) disable iff (sys_rst) // R4
    clk_sel_rc |-> osc_rst_req && chip_rst)
    else $error("Reference clock selected without reset.");

  AST_FLAG_SET: assert property (@(posedge clk) disable iff (sys_rst) // R12
    osc_rst_req |=> st_r.osc_flag)
    else $error("Failure flag not set after forced reset.");

  AST_WDT_KEEP: assert property (@(posedge clk) disable iff (sys_rst) // R6
    osc_rst_req && !ext_rst_req && !wdt_rst_evt |=> $stable(st_r.wdt_flag))
    else $error("Failure reset altered the watchdog flag.");

  AST_EXT_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // R14
    ext_rst_req && !osc_rst_req && !wdt_rst_evt |=> !st_r.osc_flag && !st_r.wdt_flag)
    else $error("External reset left a status flag set.");

  AST_FINAL_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R9
    st_r.state == OFM_FAIL && meas_valid && !main_slow |=>
      (clk_sel_rc && osc_rst_req) [*2])
    else $error("Final phase released reset early.");

  AST_FINAL_END: assert property (@(posedge clk) disable iff (sys_rst) // R10
    st_r.state == OFM_FINAL && st_r.final_cnt == FW'(FINAL_CYCLES - 1) && !(meas_valid && main_slow)
      |=> !clk_sel_rc && !osc_rst_req)
    else $error("Final phase did not return to the main clock.");

  AST_EXT_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R11
    $fell(osc_rst_req) && ext_rst_req |-> chip_rst)
    else $error("Chip left reset while external reset was active.");

  AST_SW_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // R13
    reg_wr && !chip_rst |=> st_r.osc_flag == $past(sfr_wdata[OFM_OSC_FLAG_BIT]))
    else $error("Software write to the failure flag ignored.");

  AST_WDT_STOP: assert property (@(posedge clk) disable iff (sys_rst) // R7
    osc_rst_req |-> wdt_stop)
    else $error("Failure reset did not stop the watchdog.");

endmodule
`default_nettype wire

// ### hw/ofm_pkg.sv
// Shared constants of the oscillator failure monitor.
// Assumes a single 50 MHz system clock that samples both oscillator levels.
package ofm_pkg;

  // ----------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFM_STATUS_ADDR = 8'hA9;
  localparam logic [7:0] OFM_STATUS_RESET = 8'h00;
  localparam int OFM_OSC_FLAG_BIT = 7;
  localparam int OFM_WDT_FLAG_BIT = 6;
  localparam int OFM_PRIO_MSB = 5;

  // ----------------------------------------------------------------
  // Measurement and timing.
  // ----------------------------------------------------------------
  localparam int OFM_RC_DIVIDE = 5;
  localparam int OFM_EDGE_CNT_W = 4;
  localparam int OFM_CLK_KHZ = 50000;
  localparam int OFM_FINAL_TIME_US = 1000;
  // Round down so the final phase never outlasts its nominal length.
  localparam int OFM_FINAL_CYCLES = (OFM_FINAL_TIME_US * OFM_CLK_KHZ) / 1000;

endpackage

// ### sim/ofm_osc_model.sv
// Partner model: the main crystal oscillator and the RC reference, as sampled levels.
// Assumes one bench clock; the bench starts and stops the crystal through main_run.
`timescale 1ns/1ps
`default_nettype none
module ofm_osc_model
(
  input wire logic clk,
  input wire logic main_run,
  output logic main_osc_in,
  output logic rc_osc_in
);
  logic [1:0] div_r = 2'h0;
  logic main_r = 1'b0;
  logic rc_r = 1'b0;

  // Each level has a single procedural driver; the ports only follow it.
  assign main_osc_in = main_r;
  assign rc_osc_in = rc_r;

  // The RC level flips every fourth cycle, so one divided period is 40 cycles.
  // A dead crystal freezes its level, which gives no rising edge at all.
  always @(posedge clk)
  begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3)
    begin
      rc_r <= ~rc_r;
    end
    if (main_run)
    begin
      main_r <= ~main_r;
    end
  end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the oscillator failure monitor.
// Assumes ofm_pkg is compiled first; reads are checked from a queue of notes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int FIN = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic main_run = 1'b1;
  logic ext_rst_req = 1'b0;
  logic wdt_rst_evt = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic main_osc_in, rc_osc_in, clk_sel_rc, osc_rst_req, chip_rst, wdt_stop;
  logic [7:0] exp_q[$];
  logic rd_q = 1'b0;
  logic held;
  logic [7:0] v;
  int n;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;

  ofm_osc_model i_ofm_osc_model (.clk(clk), .main_run(main_run), .main_osc_in(main_osc_in),
    .rc_osc_in(rc_osc_in));
  ofm_monitor #(.FINAL_CYCLES(FIN)) i_ofm_monitor (.clk(clk), .sys_rst(sys_rst),
    .main_osc_in(main_osc_in), .rc_osc_in(rc_osc_in), .ext_rst_req(ext_rst_req),
    .wdt_rst_evt(wdt_rst_evt), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .clk_sel_rc(clk_sel_rc),
    .osc_rst_req(osc_rst_req), .chip_rst(chip_rst), .wdt_stop(wdt_stop));

  // -----------------------------------------------------------
  // Clock, watchdog on the run and read monitor.
  // -----------------------------------------------------------
  always #10 clk = ~clk;

  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // A hang is cut off well past the few hundred cycles the tests need.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      final_report();
    end
  end

  // Read data stands for one cycle after the read edge, so it is taken mid-cycle.
  always @(posedge clk) rd_q <= sfr_rd;
  always @(negedge clk)
    if (rd_q && exp_q.size() > 0)
      check(sfr_rdata, exp_q.pop_front());

  // -----------------------------------------------------------
  // Drivers: inputs change 2 ns after the rising edge.
  // -----------------------------------------------------------
  task tick;
    @(posedge clk);
    #2;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick();
    sfr_wr = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    exp_q.push_back(e);
    tick();
    sfr_rd = 1'b0;
    tick();
  endtask

  // Waits for the clock select to reach a level; notes whether reset held meanwhile.
  task automatic wait_sel(input logic want, output int cnt);
    cnt = 0;
    held = 1'b1;
    while (clk_sel_rc !== want && cnt < 200)
    begin
      if (chip_rst !== 1'b1)
        held = 1'b0;
      tick();
      cnt++;
    end
  endtask

  function automatic logic [7:0] outs;
    outs = {4'h0, clk_sel_rc, osc_rst_req, chip_rst, wdt_stop};
  endfunction

  initial
  begin
    void'($urandom(32'h09D5FAB0));
    repeat (5) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    rd(8'hA9, 8'h00);
    rd(8'h55, 8'h00);
    repeat (100) tick();
    check(outs(), 8'h00);
    $display("test reset_and_idle done");
    wr(8'hA9, 8'hBF);
    rd(8'hA9, 8'hBF);
    wr(8'hA9, 8'h00);
    rd(8'hA9, 8'h00);
    repeat (3)
    begin
      v = 8'($urandom);
      wr(8'hA9, v);
      rd(8'hA9, v);
    end
    wr(8'hA9, 8'h15);
    wdt_rst_evt = 1'b1;
    tick();
    wdt_rst_evt = 1'b0;
    rd(8'hA9, 8'h55);
    $display("test register_access done");
    main_run = 1'b0;
    wait_sel(1'b1, n);
    check(8'(n < 100), 8'h01);
    check(outs(), 8'h0F);
    tick();
    rd(8'hA9, 8'hC0);
    wr(8'hA9, 8'h3F);
    rd(8'hA9, 8'hC0);
    $display("test failure done");
    main_run = 1'b1;
    wait_sel(1'b0, n);
    check(8'(n >= FIN && n < 150), 8'h01);
    check({7'h0, held}, 8'h01);
    check(outs(), 8'h00);
    rd(8'hA9, 8'hC0);
    $display("test recovery done");
    ext_rst_req = 1'b1;
    main_run = 1'b0;
    wait_sel(1'b1, n);
    main_run = 1'b1;
    wait_sel(1'b0, n);
    check(outs(), 8'h03);
    tick();
    ext_rst_req = 1'b0;
    tick();
    check(outs(), 8'h00);
    rd(8'hA9, 8'h00);
    $display("test external_reset done");
    final_report();
  end
endmodule
`default_nettype wire
